// File: hdl/xmi_defines.svh
// Constants for the MAC-side data interface of the PHY
`ifndef XMI_DEFINES_SVH
`define XMI_DEFINES_SVH
`define XMI_MODE_W      2
`define XMI_MODE_MII    2'h0
`define XMI_MODE_RMII   2'h1
`define XMI_MODE_RGMII  2'h2
`define XMI_MODE_SGMII  2'h3
`define XMI_REF_MHZ     200
`define XMI_RMII_MHZ    50
`define XMI_MII_MHZ     25
`define XMI_DIV_RMII    (`XMI_REF_MHZ / `XMI_RMII_MHZ)
`define XMI_DIV_MII     (`XMI_REF_MHZ / `XMI_MII_MHZ)
`define XMI_CNT_W       4
`define XMI_BAD_NIBBLE  4'h5
`define XMI_SYNC_W      2
`endif

// File: hdl/xmi_pkg.sv
// Types shared by the MAC-side interface modules
package xmi_pkg;
   typedef enum logic [1:0] {
      XMI_MII,
      XMI_RMII,
      XMI_RGMII,
      XMI_SGMII
   } xmi_mode_t;
endpackage : xmi_pkg

// File: hdl/xmi_sync.sv
// Two-flop synchroniser for signals from outside the clock domain
module xmi_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         srst_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : xmi_sync

// File: hdl/xmi_clkdiv.sv
// Free-running clock divider with phase fixed by reset
`include "xmi_defines.svh"
module xmi_clkdiv #(
   parameter int DIV = 8
) (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   // Divided clock and its rising-edge and falling-edge strobes
   output logic      clk_o,
   output logic      rise_o,
   output logic      fall_o
);
   localparam logic [`XMI_CNT_W-1:0] LAST = `XMI_CNT_W'(DIV - 1);
   localparam logic [`XMI_CNT_W-1:0] HALF = `XMI_CNT_W'(DIV / 2 - 1);
   logic [`XMI_CNT_W-1:0] cnt_q;
   // Phase is tied to the reference only through reset release
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_q <= '0;
         clk_o <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
         if (cnt_q == LAST) begin
            clk_o <= 1'b1;
         end else if (cnt_q == HALF) begin
            clk_o <= 1'b0;
         end
      end
   end
   assign rise_o = (cnt_q == LAST);
   assign fall_o = (cnt_q == HALF);
endmodule : xmi_clkdiv

// File: hdl/xmi_mac_if.sv
// MAC-side data interface of the PHY: MII, RMII, RGMII and SGMII
`include "xmi_defines.svh"
module xmi_mac_if
   import xmi_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   // Mode straps, caught after reset
   input  wire logic [1:0] mode_strap_i,
   input  wire logic       rmii_master_i,
   // Receive stream from the line decoder
   input  wire logic [3:0] dec_data_i,
   input  wire logic       dec_valid_i,
   input  wire logic       dec_err_i,
   input  wire logic       dec_carrier_i,
   // Receive pins toward the MAC
   output logic      [3:0] rx_d_o,
   output logic      [3:0] rx_d_oe_o,
   output logic            rx_clk_o,
   output logic            rx_clk_oe_o,
   output logic            rx_er_o,
   output logic            rx_ctrl_o,
   output logic            rx_ser_o,
   // Transmit pins from the MAC, and the transmit clock the PHY drives toward it in MII
   input  wire logic       tx_clk_i,
   input  wire logic [3:0] tx_d_i,
   input  wire logic       tx_en_i,
   input  wire logic       tx_ser_i,
   output logic            tx_clk_o,
   output logic            tx_clk_oe_o,
   // Transmit stream toward the line encoder
   output logic      [3:0] enc_data_o,
   output logic            enc_valid_o,
   output logic            enc_err_o,
   output logic            mode_valid_o
);
   // ****************************************
   // Mode capture
   // ****************************************
   xmi_mode_t mode_q;
   logic      master_q;
   logic      armed_q;
   // Straps read one cycle after release, then frozen
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         mode_q       <= XMI_MII;
         master_q     <= 1'b0;
         armed_q      <= 1'b1;
         mode_valid_o <= 1'b0;
      end else if (armed_q) begin
         mode_q       <= xmi_mode_t'(mode_strap_i);
         master_q     <= rmii_master_i;
         armed_q      <= 1'b0;
         mode_valid_o <= 1'b1;
      end
   end
   wire is_mii   = mode_valid_o && (mode_q == XMI_MII);
   wire is_rmii  = mode_valid_o && (mode_q == XMI_RMII);
   wire is_rgmii = mode_valid_o && (mode_q == XMI_RGMII);
   wire is_sgmii = mode_valid_o && (mode_q == XMI_SGMII);

   // ****************************************
   // Clocks
   // ****************************************
   logic c25;
   logic r25;
   logic f25;
   logic c50;
   logic r50;
   logic f50;
   xmi_clkdiv #(.DIV(`XMI_DIV_MII)) u_div25 (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .clk_o     (c25),
      .rise_o    (r25),
      .fall_o    (f25)
   );
   xmi_clkdiv #(.DIV(`XMI_DIV_RMII)) u_div50 (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .clk_o     (c50),
      .rise_o    (r50),
      .fall_o    (f50)
   );
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rx_clk_o    <= 1'b0;
         rx_clk_oe_o <= 1'b0;
         tx_clk_o    <= 1'b0;
         tx_clk_oe_o <= 1'b0;
      end else begin
         rx_clk_o    <= (is_mii || is_rgmii) ? c25 : 1'b0;
         rx_clk_oe_o <= is_mii || is_rgmii;
         tx_clk_o    <= is_mii ? c25 : 1'b0;
         tx_clk_oe_o <= is_mii;
      end
   end

   // ****************************************
   // Receive path
   // ****************************************
   // Bad frames are spoiled in the data so a MAC ignoring the error pin drops them
   wire [3:0] rx_nib = dec_err_i ? `XMI_BAD_NIBBLE : dec_data_i;
   logic      dibit_hi_q;
   logic      err_q;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rx_d_o     <= '0;
         rx_d_oe_o  <= '0;
         rx_er_o    <= 1'b0;
         rx_ctrl_o  <= 1'b0;
         rx_ser_o   <= 1'b0;
         dibit_hi_q <= 1'b0;
         err_q      <= 1'b0;
      end else begin
         rx_ser_o <= is_sgmii && dec_valid_i && rx_nib[0];
         if (is_mii || is_rgmii) begin
            rx_d_oe_o <= 4'hf;
            if (r25) begin
               rx_d_o  <= dec_valid_i ? rx_nib : '0;
               err_q   <= dec_valid_i && dec_err_i;
               rx_er_o <= is_mii && dec_valid_i && dec_err_i;
            end
            // Control pin: RGMII gives valid in high half, error in low half; MII gives valid only
            if (is_rgmii && r25) begin
               rx_ctrl_o <= dec_valid_i;
            end else if (is_rgmii && f25) begin
               rx_ctrl_o <= err_q;
            end else if (is_mii && r25) begin
               rx_ctrl_o <= dec_valid_i;
            end
         end else if (is_rmii) begin
            rx_d_oe_o <= {master_q, 3'h3};
            rx_d_o[3] <= master_q ? c50 : 1'b0;
            rx_d_o[2] <= 1'b0;
            if (r50) begin
               rx_d_o[1:0] <= !dec_valid_i ? 2'h0 :
                              dibit_hi_q ? rx_nib[3:2] : rx_nib[1:0];
               dibit_hi_q  <= dec_valid_i && !dibit_hi_q;
               rx_er_o     <= dec_valid_i && dec_err_i;
            end
            rx_ctrl_o <= dec_carrier_i || dec_valid_i;
         end else begin
            rx_d_oe_o <= '0;
            rx_d_o    <= '0;
            rx_er_o   <= 1'b0;
            rx_ctrl_o <= 1'b0;
         end
      end
   end

   // ****************************************
   // Transmit path
   // ****************************************
   logic [6:0] tx_s;
   xmi_sync #(.W(7)) u_sync (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .async_i   ({tx_clk_i, tx_d_i, tx_en_i, tx_ser_i}),
      .sync_o    (tx_s)
   );
   logic txc_q;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         txc_q <= 1'b0;
      end else begin
         txc_q <= tx_s[6];
      end
   end
   wire txc_rise = tx_s[6] && !txc_q;
   wire txc_fall = !tx_s[6] && txc_q;
   logic tx_lo_q;
   logic tx_half_q;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         enc_data_o  <= '0;
         enc_valid_o <= 1'b0;
         enc_err_o   <= 1'b0;
         tx_lo_q     <= 1'b0;
         tx_half_q   <= 1'b0;
      end else if (is_mii && r25) begin
         enc_data_o  <= tx_s[5:2];
         enc_valid_o <= tx_s[1];
         enc_err_o   <= 1'b0;
      end else if (is_rgmii && txc_rise) begin
         enc_data_o  <= tx_s[5:2];
         enc_valid_o <= tx_s[1];
         enc_err_o   <= 1'b0;
      end else if (is_rgmii && txc_fall) begin
         enc_err_o   <= tx_s[1] ^ enc_valid_o;
      end else if (is_rmii && r50) begin
         // Two dibits make one nibble, low pair first
         if (tx_s[1] && !tx_half_q) begin
            tx_lo_q     <= tx_s[2];
            enc_data_o  <= {2'h0, tx_s[3:2]};
            tx_half_q   <= 1'b1;
            enc_valid_o <= 1'b0;
         end else if (tx_s[1]) begin
            enc_data_o  <= {tx_s[3:2], enc_data_o[1:0]};
            enc_valid_o <= 1'b1;
            tx_half_q   <= 1'b0;
         end else begin
            enc_valid_o <= 1'b0;
            tx_half_q   <= 1'b0;
         end
      end else if (is_sgmii) begin
         enc_valid_o <= 1'b0;
         enc_data_o  <= {3'h0, tx_s[0]};
      end else if (!is_rmii) begin
         enc_valid_o <= enc_valid_o && !is_rgmii ? enc_valid_o : enc_valid_o;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_mode_frozen: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      mode_valid_o |=> $stable(mode_q)) else $error("mode changed after capture");
   chk_rxclk_idle: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (is_rmii || is_sgmii) |=> !rx_clk_oe_o) else $error("rx clock driven in wrong mode");
   chk_txclk_mii: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      is_mii |=> tx_clk_oe_o) else $error("tx clock not driven in mii");
   chk_rmii_upper: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      is_rmii |=> !rx_d_o[2]) else $error("rmii upper line not idle");
   chk_rmii_refclk: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (is_rmii && master_q) |=> rx_d_oe_o[3] && (rx_d_o[3] == $past(c50)))
      else $error("rmii reference clock missing");
   chk_rx_corrupt: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (is_mii && r25 && dec_valid_i && dec_err_i) |=> rx_d_o == `XMI_BAD_NIBBLE && rx_er_o)
      else $error("error nibble not corrupted");
   chk_rgmii_ctrl: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (is_rgmii && r25) |=> rx_ctrl_o == $past(dec_valid_i)) else $error("rgmii ctrl wrong");
   chk_sgmii_quiet: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      is_sgmii |=> !rx_ctrl_o && !enc_valid_o) else $error("pins active in sgmii");
   chk_rmii_crsdv: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (is_rmii && dec_carrier_i) |=> rx_ctrl_o) else $error("crs_dv missing");
endmodule : xmi_mac_if

// File: test/xmi_mac_model.sv
// MAC stand-in that drives the transmit pins of the PHY interface
module xmi_mac_model (
   // Control from the bench
   input  wire logic       rgmii_i,
   input  wire logic       rmii_i,
   input  wire logic       en_i,
   input  wire logic [3:0] nib_i,
   // Clocks from the PHY
   input  wire logic       dev_clk_i,
   input  wire logic       ref50_i,
   // Transmit pins
   output logic            tx_clk_o,
   output logic      [3:0] tx_d_o,
   output logic            tx_en_o,
   output logic            tx_ser_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mac_clk;
   initial tx_clk_o = 1'b0;
   initial tx_d_o = 4'h0;
   initial tx_en_o = 1'b0;
   initial tx_ser_o = 1'b0;
   // Own link clock only in RGMII; it stands still otherwise
   always #62.5 tx_clk_o = rgmii_i ? ~tx_clk_o : 1'b0;
   assign mac_clk = rgmii_i ? tx_clk_o : (rmii_i ? ref50_i : dev_clk_i);
   // Launch on the fall so data is settled well ahead of the rise
   always @(negedge mac_clk) begin
      tx_en_o  <= en_i;
      // Idle data lines keep changing so a stale value is never mistaken for data
      tx_d_o   <= en_i ? nib_i : ~tx_d_o;
      tx_ser_o <= ~tx_ser_o;
   end
endmodule : xmi_mac_model

// File: test/xmi_mac_if_tb.sv
// Self-checking bench for the MAC-side PHY interface
`include "xmi_defines.svh"
module xmi_mac_if_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic [1:0] mode_strap_i = `XMI_MODE_MII;
   logic       rmii_master_i = 1'b0;
   logic [3:0] dec_data_i = 4'h0;
   logic       dec_valid_i = 1'b0, dec_err_i = 1'b0, dec_carrier_i = 1'b0;
   logic [3:0] rx_d_o, rx_d_oe_o, tx_d_i, enc_data_o;
   logic       rx_clk_o, rx_clk_oe_o, rx_er_o, rx_ctrl_o, rx_ser_o;
   logic       tx_clk_i, tx_en_i, tx_ser_i, tx_clk_o, tx_clk_oe_o;
   logic       enc_valid_o, enc_err_o, mode_valid_o;
   logic       m_rgmii = 1'b0, m_rmii = 1'b0, m_en = 1'b0;
   logic [3:0] m_nib = 4'h0;
   int         miscompares = 0, cmp_count = 0, cycles = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   xmi_mac_if u_xmi_mac_if (.ref_clk_i, .srst_i, .mode_strap_i, .rmii_master_i, .dec_data_i,
      .dec_valid_i, .dec_err_i, .dec_carrier_i, .rx_d_o, .rx_d_oe_o, .rx_clk_o, .rx_clk_oe_o,
      .rx_er_o, .rx_ctrl_o, .rx_ser_o, .tx_clk_i, .tx_d_i, .tx_en_i, .tx_ser_i, .tx_clk_o,
      .tx_clk_oe_o, .enc_data_o, .enc_valid_o, .enc_err_o, .mode_valid_o);
   xmi_mac_model u_xmi_mac_model (.rgmii_i(m_rgmii), .rmii_i(m_rmii), .en_i(m_en),
      .nib_i(m_nib), .dev_clk_i(tx_clk_o), .ref50_i(rx_d_o[3]), .tx_clk_o(tx_clk_i),
      .tx_d_o(tx_d_i), .tx_en_o(tx_en_i), .tx_ser_o(tx_ser_i));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : tick
   // Outputs are read at the falling edge, well clear of the launching edge
   task automatic look(input int n);
      repeat (n) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : look
   task automatic set_io(input logic v, input logic e, input logic [3:0] d, input logic [3:0] t);
      @(posedge ref_clk_i);
      dec_valid_i   <= v;
      dec_carrier_i <= v;
      dec_err_i     <= e;
      dec_data_i    <= d;
      m_en          <= 1'b1;
      m_nib         <= t;
   endtask : set_io
   task automatic do_reset(input logic [1:0] mode, input logic master);
      int n;
      @(posedge ref_clk_i);
      srst_i        <= 1'b1;
      mode_strap_i  <= mode;
      rmii_master_i <= master;
      m_rgmii       <= (mode == `XMI_MODE_RGMII);
      m_rmii        <= (mode == `XMI_MODE_RMII);
      tick(8);
      chk("ctrl in reset", 8'h00, 8'(rx_ctrl_o));
      srst_i <= 1'b0;
      n = 0;
      while (mode_valid_o !== 1'b1 && n < 16) begin
         tick(1);
         n++;
      end
      chk("mode valid", 8'h01, 8'(mode_valid_o));
      // The strap moves after capture; pin roles must not follow it
      mode_strap_i <= ~mode;
   endtask : do_reset
   task automatic count_clks(input logic [7:0] erx, input logic [7:0] etx, input logic [7:0] eref);
      int nrx, ntx, nref;
      logic prx, ptx, pref;
      nrx = 0;
      ntx = 0;
      nref = 0;
      @(negedge ref_clk_i);
      prx = rx_clk_o;
      ptx = tx_clk_o;
      pref = rx_d_o[3];
      repeat (80) begin
         @(negedge ref_clk_i);
         if (rx_clk_o === 1'b1 && prx === 1'b0) nrx++;
         if (tx_clk_o === 1'b1 && ptx === 1'b0) ntx++;
         if (rx_d_o[3] === 1'b1 && pref === 1'b0) nref++;
         prx = rx_clk_o;
         ptx = tx_clk_o;
         pref = rx_d_o[3];
      end
      chk("rx clk rises", erx, 8'(nrx));
      chk("tx clk rises", etx, 8'(ntx));
      if (eref != 8'hff) chk("ref50 rises", eref, 8'(nref));
   endtask : count_clks
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_mii();
      do_reset(`XMI_MODE_MII, 1'b0);
      set_io(1'b1, 1'b0, 4'ha, 4'h6);
      look(64);
      chk("mii rx data", 8'h0a, 8'(rx_d_o));
      chk("mii rx oe", 8'h0f, 8'(rx_d_oe_o));
      chk("mii valid", 8'h01, 8'(rx_ctrl_o));
      chk("mii rx er", 8'h00, 8'(rx_er_o));
      chk("mii tx data", 8'h06, 8'(enc_data_o));
      chk("mii tx valid", 8'h01, 8'(enc_valid_o));
      count_clks(8'd10, 8'd10, 8'hff);
      set_io(1'b1, 1'b1, 4'ha, 4'h6);
      look(32);
      chk("mii err", 8'h01, 8'(rx_er_o));
      chk("mii bad data", 8'h05, 8'(rx_d_o));
   endtask : t_mii
   task automatic t_rmii();
      int n;
      do_reset(`XMI_MODE_RMII, 1'b1);
      set_io(1'b1, 1'b0, 4'hf, 4'hf);
      look(64);
      chk("rmii dibit", 8'h03, 8'(rx_d_o[1:0]));
      chk("rmii d2 oe", 8'h00, 8'(rx_d_oe_o[2]));
      chk("rmii crs dv", 8'h01, 8'(rx_ctrl_o));
      chk("rmii clk oe", 8'h00, 8'(rx_clk_oe_o));
      // A nibble is whole only in the period where the second dibit landed
      n = 0;
      while (enc_valid_o !== 1'b1 && n < 8) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk("rmii tx valid", 8'h01, 8'(enc_valid_o));
      chk("rmii tx data", 8'h0f, 8'(enc_data_o));
      count_clks(8'd0, 8'd0, 8'd20);
      set_io(1'b1, 1'b1, 4'hf, 4'hf);
      look(32);
      chk("rmii err", 8'h01, 8'(rx_er_o));
   endtask : t_rmii
   task automatic t_rgmii();
      logic prev;
      int   n;
      do_reset(`XMI_MODE_RGMII, 1'b0);
      set_io(1'b1, 1'b0, 4'h3, 4'h9);
      look(200);
      chk("rgmii rx data", 8'h03, 8'(rx_d_o));
      // Control shows valid in the high half of the clock, error in the low half
      n = 0;
      prev = rx_clk_o;
      @(negedge ref_clk_i);
      while (!(rx_clk_o === 1'b1 && prev === 1'b0) && n < 16) begin
         prev = rx_clk_o;
         @(negedge ref_clk_i);
         n++;
      end
      chk("rgmii ctrl a", 8'h01, 8'(rx_ctrl_o));
      repeat (4) @(negedge ref_clk_i);
      chk("rgmii ctrl b", 8'h00, 8'(rx_ctrl_o));
      chk("rgmii rx er", 8'h00, 8'(rx_er_o));
      chk("rgmii tx data", 8'h09, 8'(enc_data_o));
      chk("rgmii tx en", 8'h01, 8'(enc_valid_o));
      chk("rgmii tx err", 8'h00, 8'(enc_err_o));
      chk("rgmii txclk oe", 8'h00, 8'(tx_clk_oe_o));
      count_clks(8'd10, 8'd0, 8'hff);
   endtask : t_rgmii
   task automatic t_sgmii();
      do_reset(`XMI_MODE_SGMII, 1'b0);
      set_io(1'b1, 1'b1, 4'hc, 4'h3);
      look(64);
      chk("sgmii ctrl", 8'h00, 8'(rx_ctrl_o));
      chk("sgmii rx er", 8'h00, 8'(rx_er_o));
      chk("sgmii tx en", 8'h00, 8'(enc_valid_o));
      count_clks(8'd0, 8'd0, 8'hff);
   endtask : t_sgmii
   // ****************************************
   // Main sequence and hang guard
   // ****************************************
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      tick(8);
      t_mii();
      t_rmii();
      t_rgmii();
      t_sgmii();
      tally_and_finish();
   end
endmodule : xmi_mac_if_tb
